/* core/srt_refresh_timer.sv */
// sdram refresh interval timer, mode-set steering and apb register file
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module srt_refresh_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,

  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // sdram sequencer side
  input wire srt_pkg::srt_sdram_req_s sdram_req,
  input wire logic sdram_busy,
  output srt_pkg::srt_sdram_cmd_s sdram_cmd,

  // interrupt
  output logic irq
);
  import srt_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0] clk_sel;
  logic refresh_enable;
  logic compare_match_flag;
  logic match_flag_armed;
  logic mode_register_set_enable;
  logic [CNT_W-1:0] refresh_timer_count;
  logic [CNT_W-1:0] refresh_interval_constant;
  logic [PRESC_W-1:0] presc;
  logic refresh_pending;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  wire rd = done & ~pwrite;

  wire hit_sc = paddr == srt_byte_addr(IDX_SDRAM_CONTROL_WORD);
  wire hit_rc = paddr == srt_byte_addr(IDX_REFRESH_CONTROL);
  wire hit_cnt = paddr == srt_byte_addr(IDX_REFRESH_TIMER_COUNT);
  wire hit_const = paddr == srt_byte_addr(IDX_REFRESH_INTERVAL_CONSTANT);
  wire hit_stat = paddr == srt_byte_addr(IDX_IRQ_STATUS);
  wire hit_mask = paddr == srt_byte_addr(IDX_IRQ_MASK);
  wire mapped = hit_sc | hit_rc | hit_cnt | hit_const | hit_stat | hit_mask;

  wire wr_sc = wr & hit_sc;
  wire wr_rc = wr & hit_rc;
  wire wr_cnt = wr & hit_cnt;
  wire wr_const = wr & hit_const;
  wire wr_mask = wr & hit_mask;
  wire rd_rc = rd & hit_rc;
  wire rd_stat = rd & hit_stat;

  // ----------------------------------------------------------------
  // read data views
  // ----------------------------------------------------------------
  wire [15:0] rc_view = {compare_match_flag, 4'h0, clk_sel, refresh_enable, 7'h00};
  wire [15:0] sc_view = {mode_register_set_enable, 15'h0000};

  wire [31:0] next_rdata =
    hit_sc ? {16'h0000, sc_view} :
    hit_rc ? {16'h0000, rc_view} :
    hit_cnt ? {24'h000000, refresh_timer_count} :
    hit_const ? {24'h000000, refresh_interval_constant} :
    hit_stat ? {29'h00000000, irq_status} :
    hit_mask ? {29'h00000000, irq_mask} :
    32'h00000000;

  // ----------------------------------------------------------------
  // prescaler and count tick
  // ----------------------------------------------------------------
  // code zero clears the prescaler and holds the counter still
  wire running = clk_sel != CLK_SEL_OFF;
  wire [3:0] div_shift = srt_div_shift(clk_sel);
  wire [PRESC_W-1:0] div_mask = PRESC_W'((13'h0001 << div_shift) - 13'h0001);
  wire tick = running & ((presc & div_mask) == div_mask);
  wire [PRESC_W-1:0] next_presc = running ? presc + 12'h001 : 12'h000;

  // ----------------------------------------------------------------
  // compare and counter
  // ----------------------------------------------------------------
  // equality is tested at every count, so a value written equal still matches
  wire match = tick & (refresh_timer_count == refresh_interval_constant);

  // a software write to the counter takes precedence over counting
  wire [CNT_W-1:0] next_refresh_timer_count =
    wr_cnt ? pwdata[CNT_W-1:0] :
    match ? COUNT_RST :
    tick ? refresh_timer_count + 8'h01 :
    refresh_timer_count;

  // ----------------------------------------------------------------
  // match flag: read as one, then write zero, clears it
  // ----------------------------------------------------------------
  // arming uses the value actually returned to software (latched at setup)
  wire flag_clear = wr_rc & match_flag_armed & ~pwdata[RC_MATCH_FLAG_BIT];
  wire next_compare_match_flag = match | (compare_match_flag & ~flag_clear);
  wire next_match_flag_armed =
    (rd_rc & prdata[RC_MATCH_FLAG_BIT]) | (match_flag_armed & ~flag_clear);

  // ----------------------------------------------------------------
  // refresh request and sdram command steering
  // ----------------------------------------------------------------
  // a new write strobe also counts as a bus cycle starting now
  wire bus_idle = ~sdram_busy & ~sdram_req.strobe;
  wire issue = refresh_pending & bus_idle;
  wire next_refresh_pending = (match & refresh_enable) | (refresh_pending & ~issue);

  wire mode_set = sdram_req.strobe & mode_register_set_enable;
  wire pass_write = sdram_req.strobe & ~mode_register_set_enable;

  srt_sdram_cmd_s next_cmd;
  assign next_cmd.refresh = issue;
  assign next_cmd.mode_set = mode_set;
  assign next_cmd.pass_write = pass_write;
  assign next_cmd.addr = sdram_req.addr;

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  wire [IRQ_W-1:0] irq_events = {mode_set, issue, match};
  // only bits that software actually saw are cleared, so a late event survives
  wire [IRQ_W-1:0] irq_clear = rd_stat ? prdata[IRQ_W-1:0] : 3'h0;
  wire [IRQ_W-1:0] next_irq_status = irq_events | (irq_status & ~irq_clear);

  // ----------------------------------------------------------------
  // apb response registers
  // ----------------------------------------------------------------
  // zero wait state: pready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? next_rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel <= CLK_SEL_OFF;
      refresh_enable <= 1'b0;
    end else if (wr_rc) begin
      clk_sel <= pwdata[RC_CLK_SEL_MSB:RC_CLK_SEL_LSB];
      refresh_enable <= pwdata[RC_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_register_set_enable <= 1'b0;
    end else if (wr_sc) begin
      mode_register_set_enable <= pwdata[SC_MODE_SET_ENABLE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_interval_constant <= INTERVAL_RST;
    end else if (wr_const) begin
      refresh_interval_constant <= pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask <= pwdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // timer state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 12'h000;
      refresh_timer_count <= COUNT_RST;
    end else begin
      presc <= next_presc;
      refresh_timer_count <= next_refresh_timer_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_flag <= 1'b0;
      match_flag_armed <= 1'b0;
      refresh_pending <= 1'b0;
    end else begin
      compare_match_flag <= next_compare_match_flag;
      match_flag_armed <= next_match_flag_armed;
      refresh_pending <= next_refresh_pending;
    end
  end

  // ----------------------------------------------------------------
  // sdram command and interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdram_cmd <= '0;
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      sdram_cmd <= next_cmd;
      irq_status <= next_irq_status;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

/* pkg/srt_pkg.sv */
// shared constants, field layout and carriers for the sdram refresh timer
// Summary of operation
// - three-bit clock select picks one of seven prescaled clocks; 010 divides by eight
// - counter stays still until a nonzero clock select is written
// - counter equal to interval sets the match flag and clears the counter
// - each match requests a refresh cycle only while refresh enable is one
// - interval is compared with the counter on every count, not just writes
// - counter and interval constant are both eight bits wide
// - bit 7 of refresh control turns refresh on at one, off at zero
// - with mode-set enable one, an sdram write programs the mode register instead
// - with mode-set enable zero, sdram writes pass as ordinary accesses
package srt_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [23:0] IDX_SDRAM_CONTROL_WORD = 24'hfffda4;
  localparam logic [23:0] IDX_REFRESH_CONTROL = 24'hfffda6;
  localparam logic [23:0] IDX_REFRESH_TIMER_COUNT = 24'hfffda8;
  localparam logic [23:0] IDX_REFRESH_INTERVAL_CONSTANT = 24'hfffda9;
  localparam logic [23:0] IDX_IRQ_STATUS = 24'hfffdaa;
  localparam logic [23:0] IDX_IRQ_MASK = 24'hfffdab;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int PRESC_W = 12;
  localparam int SD_ADDR_W = 24;
  localparam int IRQ_W = 3;
  localparam int RC_CLK_SEL_LSB = 8;
  localparam int RC_CLK_SEL_MSB = 10;
  localparam int RC_ENABLE_BIT = 7;
  localparam int RC_MATCH_FLAG_BIT = 15;
  localparam int SC_MODE_SET_ENABLE_BIT = 15;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_REFRESH_BIT = 1;
  localparam int IRQ_MODE_SET_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_SEL_OFF = 3'h0;
  localparam logic [2:0] CLK_SEL_DIV8 = 3'h2;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'hff;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // ----------------------------------------------------------------
  // carriers towards the sdram sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic strobe;
    logic byte_size;
    logic [SD_ADDR_W-1:0] addr;
  } srt_sdram_req_s;

  typedef struct packed {
    logic refresh;
    logic mode_set;
    logic pass_write;
    logic [SD_ADDR_W-1:0] addr;
  } srt_sdram_cmd_s;

  function automatic logic [31:0] srt_byte_addr(input logic [23:0] idx);
    srt_byte_addr = {6'h00, idx, 2'h0};
  endfunction

  // log2 of the prescale ratio per clock select code
  function automatic logic [3:0] srt_div_shift(input logic [2:0] sel);
    case (sel)
      3'h1: srt_div_shift = 4'h1;
      3'h2: srt_div_shift = 4'h3;
      3'h3: srt_div_shift = 4'h5;
      3'h4: srt_div_shift = 4'h7;
      3'h5: srt_div_shift = 4'h9;
      3'h6: srt_div_shift = 4'hb;
      default: srt_div_shift = 4'hc;
    endcase
  endfunction

endpackage

/* bench/srt_refresh_timer_assertions.sv */
// port checker for the sdram refresh timer
`timescale 1ns/1ps
module srt_refresh_timer_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sdram side
  input wire srt_pkg::srt_sdram_req_s sdram_req,
  input wire logic sdram_busy,
  input wire srt_pkg::srt_sdram_cmd_s sdram_cmd
);
  import srt_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("late ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready too long");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_steer_one: assert property (
    sdram_req.strobe |=> sdram_cmd.mode_set ^ sdram_cmd.pass_write)
    else $error("write not steered");
  a_addr_copy: assert property (
    sdram_req.strobe |=> sdram_cmd.addr == $past(sdram_req.addr))
    else $error("address not copied");
  a_cmd_cause: assert property (
    sdram_cmd.mode_set || sdram_cmd.pass_write |-> $past(sdram_req.strobe))
    else $error("command without strobe");
  a_refresh_waits: assert property (
    sdram_cmd.refresh |-> !$past(sdram_busy) && !$past(sdram_req.strobe))
    else $error("refresh during bus cycle");
  a_refresh_pulse: assert property (
    sdram_cmd.refresh |=> !sdram_cmd.refresh)
    else $error("refresh held");
  c_refresh: cover property (sdram_cmd.refresh);
  c_mode_set: cover property (sdram_cmd.mode_set);
  c_unmapped: cover property (pslverr);
endmodule

bind srt_refresh_timer srt_refresh_timer_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sdram_req(sdram_req), .sdram_busy(sdram_busy), .sdram_cmd(sdram_cmd));

/* bench/srt_sdram_model.sv */
// behavioural sdram sequencer facing the refresh timer
`timescale 1ns/1ps
module srt_sdram_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // towards the timer
  input wire logic hold,
  input wire srt_pkg::srt_sdram_cmd_s sdram_cmd,
  output srt_pkg::srt_sdram_req_s sdram_req,
  output logic sdram_busy,
  output int ref_cnt,
  output int ms_cnt,
  output int pw_cnt
);
  import srt_pkg::*;
  logic [1:0] run;
  // any command keeps the memory busy for three cycles
  assign sdram_busy = hold | (run != 2'h0);
  initial sdram_req = {1'b0, 1'b0, 24'ha5a5a5};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 2'h0;
      ref_cnt <= 0;
      ms_cnt <= 0;
      pw_cnt <= 0;
    end else begin
      if (sdram_cmd.refresh || sdram_cmd.mode_set || sdram_cmd.pass_write) run <= 2'h3;
      else if (run != 2'h0) run <= run - 2'h1;
      ref_cnt <= ref_cnt + int'(sdram_cmd.refresh);
      ms_cnt <= ms_cnt + int'(sdram_cmd.mode_set);
      pw_cnt <= pw_cnt + int'(sdram_cmd.pass_write);
    end
  end
  // released address lines show the inverse, not the last value
  task automatic send_write(input logic [23:0] a);
    sdram_req <= {1'b1, 1'b1, a};
    @(posedge pclk);
    sdram_req <= {1'b0, 1'b0, ~a};
  endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the sdram refresh timer
`timescale 1ns/1ps
module testbench;
  import srt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, hold, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  srt_sdram_req_s sdram_req;
  srt_sdram_cmd_s sdram_cmd;
  logic sdram_busy;
  int ref_cnt, ms_cnt, pw_cnt, failures, cmp_count, n;

  srt_refresh_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sdram_req(sdram_req), .sdram_busy(sdram_busy),
    .sdram_cmd(sdram_cmd), .irq(irq));
  srt_sdram_model u_mem (.pclk(pclk), .presetn(presetn), .hold(hold), .sdram_cmd(sdram_cmd),
    .sdram_req(sdram_req), .sdram_busy(sdram_busy), .ref_cnt(ref_cnt), .ms_cnt(ms_cnt),
    .pw_cnt(pw_cnt));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request stands until pready is seen high at a rising edge; data is taken there
  task automatic apb(input logic w, input logic [23:0] i, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h00, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rc(input logic [23:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_irq;
    for (n = 0; n < 500 && irq !== 1'b1; n++) @(posedge pclk);
    if (irq !== 1'b1) begin
      failures++;
      finish_test();
    end
  endtask

  initial begin
    {psel, penable, pwrite, hold, paddr, pwdata} = '0;
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(IDX_REFRESH_CONTROL, 32'h0);
    rc(IDX_REFRESH_INTERVAL_CONSTANT, 32'hff);
    repeat (40) @(posedge pclk);
    rc(IDX_REFRESH_TIMER_COUNT, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 32'h1);
    apb(1'b1, IDX_REFRESH_INTERVAL_CONSTANT, 32'h30);
    hold <= 1'b1;
    apb(1'b1, IDX_REFRESH_CONTROL, 32'h0280);
    wait_irq();
    // 0x31 ticks of eight clocks, plus flag and irq register stages
    chk(32'((n >= 388) && (n <= 400)), 32'h1);
    chk(32'(ref_cnt), 32'h0);
    hold <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(ref_cnt), 32'h1);
    rc(IDX_REFRESH_CONTROL, 32'h8280);
    apb(1'b1, IDX_REFRESH_CONTROL, 32'h0200);
    rc(IDX_REFRESH_CONTROL, 32'h0200);
    rc(IDX_IRQ_STATUS, 32'h3);
    rc(IDX_IRQ_STATUS, 32'h0);
    apb(1'b1, IDX_IRQ_MASK, 32'h0);
    repeat (400) @(posedge pclk);
    chk(32'(ref_cnt), 32'h1);
    chk({31'h0, irq}, 32'h0);
    rc(IDX_IRQ_STATUS, 32'h1);
    rc(IDX_REFRESH_CONTROL, 32'h8200);
    apb(1'b1, IDX_SDRAM_CONTROL_WORD, 32'h8000);
    u_mem.send_write(24'h000123);
    repeat (3) @(posedge pclk);
    chk(32'(ms_cnt), 32'h1);
    apb(1'b1, IDX_SDRAM_CONTROL_WORD, 32'h0);
    u_mem.send_write(24'h000456);
    repeat (3) @(posedge pclk);
    chk(32'(pw_cnt), 32'h1);
    chk(32'(ms_cnt), 32'h1);
    apb(1'b0, 24'hfffda5, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, IDX_REFRESH_CONTROL, 32'h0);
    apb(1'b1, IDX_REFRESH_TIMER_COUNT, 32'h55);
    rc(IDX_REFRESH_TIMER_COUNT, 32'h55);
    finish_test();
  end
endmodule
